// ---- core/sfqdr_pkg.sv ----
// Constants, types and tables shared by the flash read-path design files
// What this block does
// R1: EBh: 3/4-byte address by setting; ECh: 4-byte.
// R2: Four-line read address: one nibble per clock.
// R3: Four-line operation needs quad-enable bit set.
// R4: Four-line read waits latency-code dummy cycles.
// R5: Four-line data: one nibble per falling edge.
// R6: Address increments per byte, wraps to zero.
// R7: Mode nibble Ah keeps continuous read mode.
// R8: Other mode value exits at chip-select rise.
// R9: Short invalid framed access exits continuous mode.
// R10: Two mode cycles follow address, before dummies.
// R11: Host releases lines before first data fall.
// R12: Host holds select low through mode, dummies.
// R13: 0Dh: 3/4-byte address by setting; 0Eh: 4-byte.
// R14: Both-edge read moves address on both edges.
// R15: High-performance table: opcode, address, latency only.
// R16: Both-edge latency follows latency code; input ignored.
// R17: Both-edge data: one bit per edge, one line.
// R18: Enhanced table: four mode cycles; complement continues.
// R19: Non-complement mode exits at chip-select rise.
// R20: Hold pause ignored throughout both-edge read; code still honours hold in the opcode unless the previous read was both-edge.
// R21: Learning pattern driven on every active line.
// R22: Pattern fills four cycles before first data; code drives fewer when the latency code gives fewer dummy edges.
// R23: Opcode sampled on rising edges, MSB first.
// R24: Stored extended-addressing bit picks address width.
package sfqdr_pkg;
	localparam logic [7:0] OP_FOUR_LINE_IO_READ            = 8'hEB;
	localparam logic [7:0] OP_FOUR_LINE_IO_READ_WIDE_ADDR  = 8'hEC;
	localparam logic [7:0] OP_BOTH_EDGE_FAST_READ          = 8'h0D;
	localparam logic [7:0] OP_BOTH_EDGE_FAST_READ_WIDE_ADDR = 8'h0E;
	localparam logic [2:0] OPC_LAST_BIT      = 3'h7;
	localparam logic [5:0] QUAD_ADDR_NIB_3B  = 6'h06;
	localparam logic [5:0] QUAD_ADDR_NIB_4B  = 6'h08;
	localparam logic [5:0] DDR_ADDR_BITS_3B  = 6'h18;
	localparam logic [5:0] DDR_ADDR_BITS_4B  = 6'h20;
	localparam logic [5:0] QUAD_MODE_NIBBLES = 6'h02;
	localparam logic [5:0] DDR_MODE_BITS     = 6'h08;
	localparam logic [3:0] MODE_CONT_NIBBLE  = 4'hA;
	localparam logic [5:0] PRE_EDGES_QUAD    = 6'h04;
	localparam logic [5:0] PRE_EDGES_DDR     = 6'h08;
	localparam logic [3:0] SHORT_FRAME_EDGES = 4'h8;
	localparam logic [3:0] EDGE_SAT          = 4'h9;
	localparam logic [3:0] OE_QUAD           = 4'hF;
	localparam logic [3:0] OE_DDR            = 4'h2;
	// Dummy cycles per latency code, four bits per code, code 0 lowest
	localparam logic [15:0] QUAD_LAT_TBL     = 16'h1452;
	localparam logic [15:0] DDR_HP_LAT_TBL   = 16'h8765;
	localparam logic [15:0] DDR_EH_LAT_TBL   = 16'h6543;

	typedef struct packed {
		logic       cs_n;
		logic       sck;
		logic       hold_n;
		logic [3:0] io;
	} sfqdr_pins_t;

	typedef struct packed {
		logic       quad_en;
		logic       ext_addr;
		logic       enh_table;
		logic       dlp_en;
		logic [1:0] latency_code;
		logic [7:0] data_learning_pattern;
	} sfqdr_cfg_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPC,
		ST_ADDR,
		ST_MODE,
		ST_LAT,
		ST_DATA,
		ST_SKIP
	} sfqdr_state_t;

	localparam sfqdr_pins_t PINS_RST = 7'h50;
	localparam sfqdr_cfg_t  CFG_RST  = 14'h0000;

	function automatic logic [3:0] sfqdr_lat(input logic [15:0] tbl, input logic [1:0] lc);
		sfqdr_lat = tbl[{lc, 2'h0} +: 4];
	endfunction
endpackage

// ---- core/sfqdr_sync.sv ----
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/1ps
module sfqdr_sync #(
	parameter int             W   = 7,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// Data
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			meta_q <= RST;
			q_o    <= RST;
		end
		else
		begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// ---- core/sfqdr_mem.sv ----
// Byte array with a write port for loading and a registered read port
`timescale 1ns/1ps
module sfqdr_mem #(
	parameter int AW = 10
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	// Load port
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [7:0]    wdata_i,
	// Read port
	input  wire logic [AW-1:0] raddr_i,
	output logic      [7:0]    rdata_o
);
	logic [7:0] mem_q [2**AW];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem_q[waddr_i] <= wdata_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_o <= 8'h00;
		else
			rdata_o <= mem_q[raddr_i];
	end
endmodule

// ---- core/sfqdr_read.sv ----
// Read-command engine: four-line and both-edge reads with continuous mode
`timescale 1ns/1ps
module sfqdr_read
	import sfqdr_pkg::*;
#(
	parameter int ARRAY_AW = 24,
	parameter int MEM_AW   = 10
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              resetn_i,
	// Serial link pins
	input  wire logic              sck_i,
	input  wire logic              cs_n_i,
	input  wire logic              hold_n_i,
	input  wire logic [3:0]        io_i,
	output logic      [3:0]        io_o,
	output logic      [3:0]        io_oe_o,
	// Configuration
	input  wire logic              quad_enable_i,
	input  wire logic              extended_addressing_i,
	input  wire logic              enhanced_latency_table_i,
	input  wire logic [1:0]        latency_code_i,
	input  wire logic              dlp_enable_i,
	input  wire logic [7:0]        data_learning_pattern_i,
	// Array load
	input  wire logic              mem_we_i,
	input  wire logic [MEM_AW-1:0] mem_waddr_i,
	input  wire logic [7:0]        mem_wdata_i,
	// Status
	output logic                   continuous_mode_o,
	output logic                   busy_o
);
	sfqdr_pins_t          pin_raw;
	sfqdr_pins_t          pin_s;
	sfqdr_cfg_t           cfg_in;
	sfqdr_cfg_t           cfg_q, cfg_d;
	sfqdr_state_t         st_q, st_d;
	logic                 sck_prev_q;
	logic                 cs_prev_q;
	logic [5:0]           cnt_q, cnt_d;
	logic [7:0]           sr_q, sr_d;
	logic [31:0]          asr_q, asr_d;
	logic [ARRAY_AW-1:0]  addr_q, addr_d;
	logic [5:0]           lat_q, lat_d;
	logic [7:0]           sh_q, sh_d;
	logic [2:0]           chunk_q, chunk_d;
	logic                 ddr_q, ddr_d;
	logic                 wide_q, wide_d;
	logic                 arm_q, arm_d;
	logic                 valid_q, valid_d;
	logic                 mdone_q, mdone_d;
	logic                 mok_q, mok_d;
	logic                 cont_q, cont_d;
	logic [3:0]           redges_q, redges_d;
	logic [3:0]           io_q, io_d;
	logic [3:0]           oe_q, oe_d;
	logic [7:0]           rdata;

	assign pin_raw = '{cs_n: cs_n_i, sck: sck_i, hold_n: hold_n_i, io: io_i};
	assign cfg_in  = '{quad_en: quad_enable_i, ext_addr: extended_addressing_i,
		enh_table: enhanced_latency_table_i, dlp_en: dlp_enable_i,
		latency_code: latency_code_i, data_learning_pattern: data_learning_pattern_i};

	sfqdr_sync #(
		.W   (7),
		.RST (PINS_RST)
	) u_sync (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.d_i      (pin_raw),
		.q_o      (pin_s)
	);

	// Array holds only the low address bits; upper bits alias
	sfqdr_mem #(
		.AW (MEM_AW)
	) u_mem (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.we_i     (mem_we_i),
		.waddr_i  (mem_waddr_i),
		.wdata_i  (mem_wdata_i),
		.raddr_i  (addr_q[MEM_AW-1:0]),
		.rdata_o  (rdata)
	);

	function automatic logic [5:0] addr_len(input logic ddr, input logic wide);
		if (ddr)
			addr_len = wide ? DDR_ADDR_BITS_4B : DDR_ADDR_BITS_3B;
		else
			addr_len = wide ? QUAD_ADDR_NIB_4B : QUAD_ADDR_NIB_3B;
	endfunction

	// Link edges, seen through the synchroniser only
	wire cs_s     = pin_s.cs_n;
	wire cs_fall  = cs_prev_q & ~cs_s;
	wire cs_rise  = ~cs_prev_q & cs_s;
	wire sck_rise = ~cs_s & pin_s.sck & ~sck_prev_q;
	wire sck_fall = ~cs_s & ~pin_s.sck & sck_prev_q;
	wire hold_act = ~pin_s.hold_n & ~ddr_q; // R20
	wire rise_e   = sck_rise & ~hold_act;
	wire fall_e   = sck_fall & ~hold_act;
	// Mode 3 opens on a falling edge, so both-edge input waits for a rise
	wire in_e     = ddr_q ? (rise_e | (fall_e & arm_q)) : rise_e; // R14
	wire out_e    = ddr_q ? (rise_e | fall_e) : fall_e; // R5 R17

	// Opcode decode
	wire [7:0] op_sh   = {sr_q[6:0], pin_s.io[0]}; // R23
	wire       op_quad = op_sh == OP_FOUR_LINE_IO_READ
		|| op_sh == OP_FOUR_LINE_IO_READ_WIDE_ADDR;
	wire       op_ddr  = op_sh == OP_BOTH_EDGE_FAST_READ
		|| op_sh == OP_BOTH_EDGE_FAST_READ_WIDE_ADDR;
	wire       op_ok   = (op_quad & cfg_q.quad_en) | op_ddr; // R3
	wire       op_wide = op_sh == OP_FOUR_LINE_IO_READ_WIDE_ADDR
		|| op_sh == OP_BOTH_EDGE_FAST_READ_WIDE_ADDR || cfg_q.ext_addr; // R1 R13 R24

	// Shifted address and mode
	wire [31:0] asr_nx = ddr_q ? {asr_q[30:0], pin_s.io[0]} : {asr_q[27:0], pin_s.io}; // R2 R14
	wire [7:0]  md_nx  = ddr_q ? {sr_q[6:0], pin_s.io[0]} : {sr_q[3:0], pin_s.io};
	wire        md_ok  = ddr_q ? (md_nx[7:4] == ~md_nx[3:0]) // R18
		: (md_nx[7:4] == MODE_CONT_NIBBLE); // R7

	// Latency in output edges up to and including the first data edge
	wire [3:0] dummy   = ddr_q ? sfqdr_lat(cfg_q.enh_table ? DDR_EH_LAT_TBL : DDR_HP_LAT_TBL,
		cfg_q.latency_code) : sfqdr_lat(QUAD_LAT_TBL, cfg_q.latency_code); // R4 R16
	wire [5:0] lat_ddr = (dummy == 4'h0) ? 6'h01 : {1'h0, dummy, 1'h0};
	wire [5:0] lat_st  = ddr_q ? lat_ddr : 6'({2'h0, dummy} + 6'h01);

	// Learning preamble in the last edges before data
	wire [5:0] pre_max = ddr_q ? PRE_EDGES_DDR : PRE_EDGES_QUAD;
	wire       pre_on  = cfg_q.dlp_en && lat_q >= 6'h02 && lat_q <= 6'(pre_max + 6'h01); // R22
	wire [2:0] pre_idx = 3'(lat_q - 6'h02 + (ddr_q ? 6'h00 : 6'h04));
	wire       pre_bit = cfg_q.data_learning_pattern[pre_idx];
	wire [3:0] pre_io  = ddr_q ? {2'h0, pre_bit, 1'h0} : {4{pre_bit}}; // R21
	wire [3:0] lines   = ddr_q ? OE_DDR : OE_QUAD;

	// Data chunk out of the current byte
	wire [7:0] src     = (chunk_q == 3'h0) ? rdata : sh_q;
	wire [3:0] chunk_io = ddr_q ? {2'h0, src[7], 1'h0} : src[7:4];
	wire [7:0] sh_nx   = ddr_q ? {src[6:0], 1'h0} : {src[3:0], 4'h0};
	wire [2:0] chunk_l = ddr_q ? 3'h7 : 3'h1;
	wire       short_f = redges_q <= SHORT_FRAME_EDGES && !valid_q;

	always_comb
	begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		sr_d     = sr_q;
		asr_d    = asr_q;
		addr_d   = addr_q;
		lat_d    = lat_q;
		sh_d     = sh_q;
		chunk_d  = chunk_q;
		ddr_d    = ddr_q;
		wide_d   = wide_q;
		arm_d    = arm_q | rise_e;
		valid_d  = valid_q;
		mdone_d  = mdone_q;
		mok_d    = mok_q;
		cont_d   = cont_q;
		redges_d = redges_q;
		io_d     = io_q;
		oe_d     = oe_q;
		cfg_d    = cfg_q;
		if (rise_e && redges_q != EDGE_SAT)
			redges_d = 4'(redges_q + 4'h1);
		case (st_q)
			ST_OPC:
				if (rise_e)
				begin
					sr_d  = op_sh;
					cnt_d = 6'(cnt_q + 6'h01);
					if (cnt_q[2:0] == OPC_LAST_BIT)
					begin
						st_d = ST_SKIP;
						if (op_ok)
						begin
							valid_d = 1'h1;
							ddr_d   = op_ddr;
							wide_d  = op_wide;
							cnt_d   = addr_len(op_ddr, op_wide);
							arm_d   = 1'h0;
							st_d    = ST_ADDR;
						end
					end
				end
			ST_ADDR:
				if (in_e)
				begin
					asr_d = asr_nx;
					cnt_d = 6'(cnt_q - 6'h01);
					if (cnt_q == 6'h01)
					begin
						addr_d  = asr_nx[ARRAY_AW-1:0];
						chunk_d = 3'h0;
						if (!ddr_q || cfg_q.enh_table)
						begin
							st_d  = ST_MODE; // R10 R18
							cnt_d = ddr_q ? DDR_MODE_BITS : QUAD_MODE_NIBBLES;
						end
						else
						begin
							st_d    = ST_LAT; // R15
							lat_d   = lat_st;
							mdone_d = 1'h1;
							mok_d   = 1'h0;
						end
					end
				end
			ST_MODE:
				if (in_e)
				begin
					sr_d  = md_nx;
					cnt_d = 6'(cnt_q - 6'h01);
					if (cnt_q == 6'h01)
					begin
						mdone_d = 1'h1;
						mok_d   = md_ok;
						st_d    = ST_LAT;
						lat_d   = lat_st; // R4 R16
					end
				end
			ST_LAT:
				// Input lines are not looked at while waiting
				if (out_e)
				begin
					lat_d = 6'(lat_q - 6'h01);
					if (lat_q == 6'h01)
					begin
						io_d    = chunk_io;
						oe_d    = lines;
						sh_d    = sh_nx;
						chunk_d = 3'h1;
						addr_d  = addr_q + 1'h1; // R6
						st_d    = ST_DATA;
					end
					else if (pre_on)
					begin
						io_d = pre_io; // R21 R22
						oe_d = lines;
					end
				end
			ST_DATA:
				if (out_e)
				begin
					io_d    = chunk_io; // R5 R17
					sh_d    = sh_nx;
					chunk_d = (chunk_q == chunk_l) ? 3'h0 : 3'(chunk_q + 3'h1);
					if (chunk_q == 3'h0)
						addr_d = addr_q + 1'h1; // R6
				end
			default:
			begin
			end
		endcase
		if (cs_fall)
		begin
			cfg_d    = cfg_in; // R24
			redges_d = 4'h0;
			valid_d  = 1'h0;
			mdone_d  = 1'h0;
			arm_d    = 1'h0;
			cnt_d    = 6'h00;
			st_d     = ST_OPC;
			if (cont_q)
			begin
				st_d  = ST_ADDR; // R7 R18
				cnt_d = addr_len(ddr_q, wide_q);
			end
		end
		if (cs_s)
		begin
			st_d = ST_IDLE;
			oe_d = 4'h0;
		end
		if (cs_rise)
		begin
			if (short_f)
				cont_d = 1'h0; // R9
			else if (mdone_q)
				cont_d = mok_q; // R7 R8 R19
			else if (st_q == ST_MODE || st_q == ST_LAT)
				cont_d = 1'h0; // R12
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sck_prev_q <= 1'h0;
			cs_prev_q  <= 1'h1;
			st_q       <= ST_IDLE;
			cfg_q      <= CFG_RST;
			cont_q     <= 1'h0;
			io_q       <= 4'h0;
			oe_q       <= 4'h0;
		end
		else
		begin
			sck_prev_q <= pin_s.sck;
			cs_prev_q  <= cs_s;
			st_q       <= st_d;
			cfg_q      <= cfg_d;
			cont_q     <= cont_d;
			io_q       <= io_d;
			oe_q       <= oe_d;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cnt_q    <= 6'h00;
			sr_q     <= 8'h00;
			asr_q    <= 32'h0000_0000;
			addr_q   <= '0;
			lat_q    <= 6'h00;
			sh_q     <= 8'h00;
			chunk_q  <= 3'h0;
			ddr_q    <= 1'h0;
			wide_q   <= 1'h0;
			arm_q    <= 1'h0;
			valid_q  <= 1'h0;
			mdone_q  <= 1'h0;
			mok_q    <= 1'h0;
			redges_q <= 4'h0;
		end
		else
		begin
			cnt_q    <= cnt_d;
			sr_q     <= sr_d;
			asr_q    <= asr_d;
			addr_q   <= addr_d;
			lat_q    <= lat_d;
			sh_q     <= sh_d;
			chunk_q  <= chunk_d;
			ddr_q    <= ddr_d;
			wide_q   <= wide_d;
			arm_q    <= arm_d;
			valid_q  <= valid_d;
			mdone_q  <= mdone_d;
			mok_q    <= mok_d;
			redges_q <= redges_d;
		end
	end

	assign io_o              = io_q;
	assign io_oe_o           = oe_q;
	assign continuous_mode_o = cont_q;
	assign busy_o            = st_q != ST_IDLE;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_opcode_taken;
		st_q == ST_OPC && st_d == ST_ADDR;
	endsequence
	sequence s_mode_frame_end;
		cs_rise && !short_f && mdone_q;
	endsequence

	a_quad_enable_gate: assert property (s_opcode_taken ##1 !ddr_q |-> cfg_q.quad_en) // R3
		else $error("four-line read accepted with quad enable off");
	a_addr_width_pick: assert property (s_opcode_taken |=> wide_q == $past(op_wide)
		&& cnt_q == addr_len(ddr_q, wide_q)) // R1
		else $error("address length does not match opcode and setting");
	a_addr_wrap_step: assert property (st_q == ST_DATA && out_e && chunk_q == 3'h0 && !cs_s
		|=> addr_q == ARRAY_AW'($past(addr_q) + 1'h1)) // R6
		else $error("address did not advance by one per byte");
	a_data_lines_used: assert property (st_q == ST_DATA
		|-> io_oe_o == (ddr_q ? OE_DDR : OE_QUAD)) // R17
		else $error("data driven on wrong lines");
	a_short_frame_exit: assert property (cs_rise && short_f |=> !cont_q) // R9
		else $error("short frame did not leave continuous mode");
	a_mode_decides_cont: assert property (s_mode_frame_end |=> cont_q == $past(mok_q)) // R8
		else $error("continuous mode not set from mode bits");
	a_mode_pattern_check: assert property (st_q == ST_MODE && st_d == ST_LAT
		##1 st_q == ST_LAT |-> mok_q == (ddr_q ? sr_q[7:4] == ~sr_q[3:0]
		: sr_q[7:4] == MODE_CONT_NIBBLE)) // R19
		else $error("mode pattern judged wrongly");
	a_hp_skips_mode: assert property (st_q == ST_ADDR && ddr_q && !cfg_q.enh_table
		|=> st_q != ST_MODE) // R15
		else $error("mode cycles taken with high-performance table");
	a_first_data_edge: assert property (st_q == ST_LAT && out_e && lat_q == 6'h01 && !cs_s
		|=> st_q == ST_DATA ##1 io_oe_o == lines) // R16
		else $error("data did not start after the latency count");
	a_hold_ignored_ddr: assert property (ddr_q && sck_rise |-> rise_e) // R20
		else $error("hold paused a both-edge read");
	a_preamble_lines: assert property (st_q == ST_LAT && out_e && pre_on && lat_q != 6'h01
		&& !cs_s |=> io_oe_o == lines
		&& (ddr_q ? io_o[3:2] == 2'h0 && !io_o[0] : &io_o | ~|io_o)) // R21
		else $error("learning pattern not on all active lines");
	a_opcode_msb_first: assert property (st_q == ST_OPC && rise_e && !cs_fall
		|=> sr_q[0] == $past(pin_s.io[0])) // R23
		else $error("opcode bit not shifted in at rising edge");
endmodule

// ---- dv/sfqdr_host.sv ----
// Host controller model: drives serial clock, select and data lines, records line levels
`timescale 1ns/1ps
module sfqdr_host (
	// Line levels seen on the wire
	input  wire logic [3:0] io_i,
	// Pins the host drives
	output logic            sck_o,
	output logic            cs_n_o,
	output logic [3:0]      io_o,
	output logic [3:0]      io_oe_o
);
	logic [3:0] smp_q[$];

	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'h0;
		io_oe_o = 4'h0;
	end

	// Data moves at slot start and the edge comes mid-slot, so data is steady across the edge after synchronising
	task automatic slot(input logic [3:0] oe, input logic [3:0] v);
		io_o <= v;
		io_oe_o <= oe;
		#12;
		sck_o <= ~sck_o;
		#2;
		smp_q.push_back(io_i);
		#10;
	endtask

	// Sample k holds what the device launched on tail edge k; edge 0 is the last edge before the tail slots
	task automatic frame(input logic [7:0] op, input bit use_op, input bit quad, input bit enh,
			input int abits, input logic [31:0] addr, input logic [7:0] mode, input int tail);
		int i;
		cs_n_o <= 1'b0;
		#24;
		for (i = 7; i >= 0 && use_op; i--)
			repeat (2) slot(4'h1, {3'h0, op[i]});
		for (i = abits - 4; i >= 0 && quad; i -= 4)
			repeat (2) slot(4'hF, addr[i+:4]);
		for (i = 4; i >= 0 && quad; i -= 4)
			repeat (2) slot(4'hF, mode[i+:4]);
		for (i = abits - 1; i >= 0 && !quad; i--)
			slot(4'h1, {3'h0, addr[i]});
		for (i = 7; i >= 0 && !quad && enh; i--)
			slot(4'h1, {3'h0, mode[i]});
		smp_q.delete();
		repeat (tail) slot(4'h0, 4'h0);
		#24;
		cs_n_o <= 1'b1;
		#60;
	endtask
endmodule

// ---- dv/sfqdr_read_bench.sv ----
// Self-checking bench for the read-command engine against the host model
`timescale 1ns/1ps
module sfqdr_read_bench
	import sfqdr_pkg::*;
;
	typedef struct packed {
		logic [7:0]  op;
		bit          use_op;
		bit          quad;
		bit          ext;
		bit          enh;
		bit          data_learning_pattern;
		bit          hold;
		logic [1:0]  lc;
		logic [31:0] addr;
		logic [7:0]  mode;
		bit          cont;
	} sfqdr_row_t;

	localparam logic [7:0] DLP_VAL = 8'hB2;
	// op, opcode sent, four-line, ext, enhanced, preamble, hold, code, address, mode, continuous
	sfqdr_row_t rows [9] = '{
		'{8'hEB, 1, 1, 0, 0, 0, 0, 2'h0, 32'h00FF_FFFE, 8'h00, 0},
		'{8'hEB, 1, 1, 1, 0, 0, 0, 2'h2, 32'h1234_0200, 8'hA5, 1},
		'{8'hEB, 0, 1, 1, 0, 0, 0, 2'h3, 32'h0000_03FF, 8'h5A, 0},
		'{8'hEC, 1, 1, 0, 1, 1, 0, 2'h1, 32'h0000_0100, 8'h3C, 0},
		'{8'h0D, 1, 0, 0, 0, 0, 0, 2'h0, 32'h00FF_FFFF, 8'h00, 0},
		'{8'h0E, 1, 0, 1, 1, 0, 0, 2'h1, 32'h0000_0155, 8'hA5, 1},
		'{8'h0D, 0, 0, 1, 1, 0, 1, 2'h2, 32'h0000_02AA, 8'h0F, 1},
		'{8'h0D, 0, 0, 1, 1, 0, 0, 2'h3, 32'h0000_0001, 8'h55, 0},
		'{8'h0D, 1, 0, 1, 0, 1, 0, 2'h3, 32'h0000_0020, 8'h00, 0}
	};

	logic       clk_i;
	logic       resetn_i;
	logic       sck;
	logic       cs_n;
	logic       hold_n;
	logic [3:0] io_w;
	logic [3:0] d_io;
	logic [3:0] d_oe;
	logic [3:0] h_io;
	logic [3:0] h_oe;
	logic       cont;
	logic       busy;
	logic       mem_we;
	logic [9:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic       flt_q = 1'b0;
	logic       clr;
	logic [1:0] seen;
	sfqdr_cfg_t cfg;
	int         fail_count = 0;
	int         check_count = 0;

	// Released lines wander so stale data cannot pass for a drive
	assign io_w = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & {4{flt_q}});

	always @(posedge clk_i)
	begin
		flt_q <= ~flt_q;
		seen <= clr ? 2'h0 : seen | {busy, |d_oe};
	end

	sfqdr_read #(.ARRAY_AW(24), .MEM_AW(10)) dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .sck_i(sck), .cs_n_i(cs_n), .hold_n_i(hold_n),
		.io_i(io_w), .io_o(d_io), .io_oe_o(d_oe), .quad_enable_i(cfg.quad_en),
		.extended_addressing_i(cfg.ext_addr), .enhanced_latency_table_i(cfg.enh_table),
		.latency_code_i(cfg.latency_code), .dlp_enable_i(cfg.dlp_en),
		.data_learning_pattern_i(cfg.data_learning_pattern), .mem_we_i(mem_we), .mem_waddr_i(mem_waddr),
		.mem_wdata_i(mem_wdata), .continuous_mode_o(cont), .busy_o(busy));

	sfqdr_host host (.io_i(io_w), .sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .io_oe_o(h_oe));

	function automatic logic [7:0] mem_val(input logic [9:0] a);
		return a[7:0] * 8'h1D ^ {6'h00, a[9:8]} ^ 8'hA6;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic do_reset();
		resetn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		chk({busy, d_oe, cont}, 6'h00);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
	endtask

	task automatic arm(input sfqdr_cfg_t c, input logic hld);
		@(posedge clk_i);
		cfg <= c;
		hold_n <= ~hld;
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
	endtask

	// Select rise, drive release and the continuous flag all settle here
	task automatic settle(input logic [1:0] s, input logic c);
		repeat (12) @(posedge clk_i);
		chk({seen, busy, d_oe, c ^ cont}, {s, 6'h00});
	endtask

	task automatic run_row(input sfqdr_row_t r);
		int n;
		int ab;
		int k;
		int i;
		logic [7:0] b;
		logic [15:0] tb;
		tb = r.quad ? QUAD_LAT_TBL : (r.enh ? DDR_EH_LAT_TBL : DDR_HP_LAT_TBL);
		n = int'(tb[{r.lc, 2'h0} +: 4]);
		ab = (r.ext || r.op == 8'hEC || r.op == 8'h0E) ? 32 : 24;
		arm('{1'b1, r.ext, r.enh, r.data_learning_pattern, r.lc, DLP_VAL}, r.hold);
		host.frame(r.op, r.use_op, r.quad, r.enh, ab, r.addr, r.mode, 2 * n + (r.quad ? 12 : 24));
		for (k = 0; k < 3; k++)
		begin
			for (i = 0; i < 8; i++)
				b[7 - i] = r.quad ? host.smp_q[2 * n + 1 + 4 * k + 2 * (i / 4)][3 - i % 4]
					: host.smp_q[2 * n + 8 * k + i][1];
			chk(b, mem_val(r.addr[9:0] + 10'(k)));
		end
		for (i = 0; i < (r.quad ? 4 : 8) && r.data_learning_pattern; i++)
			chk(r.quad ? host.smp_q[2 * n - 7 + 2 * i] : {3'h0, host.smp_q[2 * n - 8 + i][1]},
				r.quad ? {4{DLP_VAL[7 - i]}} : {3'h0, DLP_VAL[7 - i]});
		settle(2'h3, r.cont);
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	initial
	begin
		#200_000;
		fail_count++;
		wrap_up();
	end

	initial
	begin
		int i;
		resetn_i = 1'b0;
		hold_n = 1'b1;
		mem_we = 1'b0;
		mem_waddr = 10'h000;
		mem_wdata = 8'h00;
		clr = 1'b1;
		cfg = CFG_RST;
		do_reset();
		for (i = 0; i < 1024; i++)
		begin
			@(posedge clk_i);
			mem_we <= 1'b1;
			mem_waddr <= 10'(i);
			mem_wdata <= mem_val(10'(i));
		end
		@(posedge clk_i);
		mem_we <= 1'b0;
		foreach (rows[i])
			run_row(rows[i]);
		// Short invalid framed access while continuous must drop the mode
		run_row(rows[1]);
		arm('{1'b1, 1'b1, 1'b0, 1'b0, 2'h0, DLP_VAL}, 1'b0);
		host.frame(8'h00, 1, 0, 0, 0, 32'h0000_0000, 8'h00, 0);
		settle(2'h2, 1'b0);
		arm('{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, DLP_VAL}, 1'b0);
		host.frame(8'hEB, 1, 1, 0, 24, 32'h0000_0010, 8'hA0, 16);
		settle(2'h2, 1'b0);
		run_row(rows[1]);
		do_reset();
		run_row(rows[0]);
		wrap_up();
	end
endmodule
